// ---- hw/status_pkg.sv ----
// shared constants, field positions and command codes of the status block
// assumes one system clock; the host reaches the block only through commands
package status_pkg;
  localparam int          WORD_W        = 16;
  // measurement summary event set bit positions
  localparam int          READ_OVF_BIT  = 0;
  localparam int          READ_AVL_BIT  = 6;
  localparam int          BUF_HALF_BIT  = 7;
  localparam int          BFULL_BIT     = 8;
  localparam int          BTQ_BIT       = 9;
  localparam int          BQ_BIT        = 10;
  localparam logic [15:0] MSUM_USED     = 16'h07c1;
  // lower set summary bit, instrument summary bit and operation idle bit
  localparam int          LOWER_SUM_BIT = 1;
  localparam int          INST_SUM_BIT  = 13;
  localparam int          IDLE_BIT      = 10;
  // status byte layout
  localparam int          STB_MEAS_BIT  = 0;
  localparam int          STB_EAV_BIT   = 2;
  localparam int          STB_MAV_BIT   = 4;
  localparam int          STB_RQS_BIT   = 6;
  localparam logic [7:0]  STB_SUM_MASK  = 8'hbf;
  // error queue
  localparam int          ERRQ_DEPTH    = 64;
  localparam logic [15:0] ERR_NONE      = 16'h0000;
  localparam logic [15:0] ERR_OVERFLOW  = 16'hfea2; // -350
  // output queue
  localparam int          OUTQ_DEPTH    = 8;
  localparam logic [15:0] RESET_WORD    = 16'h0000;

  typedef enum logic [4:0] {
    CMD_RD_COND_MEAS,
    CMD_RD_COND_OP,
    CMD_RD_COND_QUES,
    CMD_RD_EV_MSUM,
    CMD_RD_EV_MINST,
    CMD_RD_EV_MEAS,
    CMD_WR_EN_MSUM,
    CMD_RD_EN_MSUM,
    CMD_WR_EN_MINST,
    CMD_RD_EN_MINST,
    CMD_WR_EN_MEAS,
    CMD_RD_EN_MEAS,
    CMD_WR_SRE,
    CMD_RD_SRE,
    CMD_RD_STB,
    CMD_SPOLL,
    CMD_CLS,
    CMD_ERR_CLR,
    CMD_RD_ERR,
    CMD_TALK
  } cmd_t;
endpackage

// ---- hw/instrument_status_reporting.sv ----
// status reporting: measurement summary chain, status byte, service request,
// output queue buffer and error queue
// assumes inputs synchronous to i_sys_clk; one command taken per valid cycle
//
// Contract
// - reading overflow at bit 0, reading available at bit 6; bits 1 to 5 and 11 to 15 unused
// - buffer levels: bit 7 half, 8 full, 9 three quarter, 10 quarter
// - summary of measurement summary set drives bit 1 of next register
// - an event sets its bit, which stays latched until read or cleared
// - reading an event register returns it and clears it
// - clear-status resets every event register
// - summary is set when any event bit and its enable bit are set
// - condition registers are read-only live views, no latching
// - operation condition bit 10 follows the idle state
// - output queue is fifo; message available while it holds data
// - errors push coded messages; error available while queue non-empty
// - reading an error message removes it
// - error queue holds 64; on full the last slot holds code -350
// - error queue empty at power-up; empty read returns code 0
// - standard codes negative, maker codes positive
// - clear-status or error-clear empties the error queue
// - enabled summary rising sets bit 6 and raises service request
// - serial poll clears the request-service flag
// - status byte query reports master summary, not cleared by poll
// - enabled bit 1 of measurement instrument set sets bit 13 above
`timescale 1ns/100ps

// parameterised fifo with valid/ready on both sides
module stream_fifo
  import status_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  // pointer width of the queue
  localparam int AW = $clog2(DEPTH);

  // storage, pointers, fill count and registered handshake flags
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        rdy;
    logic                        vld;
  } fifo_st_t;

  fifo_st_t st_ff;
  fifo_st_t nxt_st;
  logic     push;
  logic     pop;

  assign o_in_ready  = st_ff.rdy;
  assign o_out_valid = st_ff.vld;
  assign o_out_data  = st_ff.mem[st_ff.rd];

  // pointer and count update; ready and valid kept as registered flags
  always_comb begin
    nxt_st = st_ff;
    push   = i_in_valid && st_ff.rdy;
    pop    = i_out_ready && st_ff.vld;
    // push writes the tail and moves the write pointer on
    if (push) begin
      nxt_st.mem[st_ff.wr] = i_in_data;
      nxt_st.wr            = (st_ff.wr == AW'(DEPTH - 1)) ? '0 : st_ff.wr + 1'b1;
    end
    // pop moves the read pointer on
    if (pop) begin
      nxt_st.rd = (st_ff.rd == AW'(DEPTH - 1)) ? '0 : st_ff.rd + 1'b1;
    end
    // count and flags follow from this cycle's push and pop
    nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    nxt_st.rdy = (nxt_st.cnt != (AW + 1)'(DEPTH));
    nxt_st.vld = (nxt_st.cnt != '0);
  end

  // ready starts high: the queue is empty out of reset
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff     <= '0;
      st_ff.rdy <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// top of the status reporting block
module instrument_status_reporting
  import status_pkg::*;
#(
  parameter int ERR_DEPTH = ERRQ_DEPTH,
  parameter int OUT_DEPTH = OUTQ_DEPTH
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  // live measurement, operation and questionable conditions
  input  wire logic        i_reading_overflow_flag,
  input  wire logic        i_reading_available_flag,
  input  wire logic        i_buffer_half_flag,
  input  wire logic        i_buffer_full_flag,
  input  wire logic        i_buffer_three_quarter_flag,
  input  wire logic        i_buffer_quarter_flag,
  input  wire logic        i_idle,
  input  wire logic [15:0] i_op_cond,
  input  wire logic [15:0] i_ques_cond,
  // host command port
  input  wire logic        i_cmd_valid,
  input  wire cmd_t        i_cmd_op,
  input  wire logic [15:0] i_cmd_data,
  output logic             o_rsp_valid,
  output logic [15:0]      o_rsp_data,
  output logic             o_srq,
  // responses produced by the instrument for the output queue
  input  wire logic        i_resp_valid,
  input  wire logic [15:0] i_resp_data,
  output logic             o_resp_ready,
  // error reports
  input  wire logic        i_err_valid,
  input  wire logic [15:0] i_err_code
);
  // address width of the error queue
  localparam int EW = $clog2(ERR_DEPTH);

  // whole block state except the output queue: event chain, enables, error queue and answer
  typedef struct packed {
    logic [15:0]                      msum_cond_d;
    logic [15:0]                      msum_ev;
    logic [15:0]                      msum_en;
    logic [15:0]                      minst_ev;
    logic [15:0]                      minst_en;
    logic [15:0]                      meas_ev;
    logic [15:0]                      meas_en;
    logic [7:0]                       sre;
    logic                             mss_d;
    logic                             rqs;
    // error queue storage, head pointer and fill count
    logic [ERR_DEPTH-1:0][15:0]       eq_mem;
    logic [EW-1:0]                    eq_rd;
    logic [EW:0]                      eq_cnt;
    // registered answer to the host
    logic                             rsp_valid;
    logic [15:0]                      rsp_data;
  } st_t;

  st_t         st_ff;
  st_t         nxt_st;
  logic [15:0] msum_cond;
  logic [15:0] op_cond;
  logic        msum_sum;
  logic        minst_sum;
  logic        meas_sum;
  logic [7:0]  stb;
  logic        mss;
  logic        mav;
  logic        talk;
  logic [15:0] outq_data;
  logic        cmd;
  logic [EW-1:0] eq_wr;
  // strobes of the command taken this cycle and error queue state
  logic          rd_ev_msum;
  logic          rd_ev_minst;
  logic          rd_ev_meas;
  logic          clr_status;
  logic          clr_errors;
  logic          wr_en_msum;
  logic          wr_en_minst;
  logic          wr_en_meas;
  logic          wr_sre;
  logic          rd_err;
  logic          poll;
  logic          eq_empty;

  // pick of one command for this cycle
  function automatic logic is_cmd(input logic v, input cmd_t op, input cmd_t want);
    is_cmd = v && (op == want);
  endfunction

  // status byte word with bit 6 chosen by the caller: summary or request flag
  function automatic logic [15:0] stb_word(input logic [7:0] s, input logic b6);
    stb_word = {8'h00, s[7], b6, s[5:0]};
  endfunction

  // live condition views
  always_comb begin
    msum_cond            = '0;
    msum_cond[READ_OVF_BIT] = i_reading_overflow_flag;
    msum_cond[READ_AVL_BIT] = i_reading_available_flag;
    msum_cond[BUF_HALF_BIT] = i_buffer_half_flag;
    msum_cond[BFULL_BIT]    = i_buffer_full_flag;
    msum_cond[BTQ_BIT]      = i_buffer_three_quarter_flag;
    msum_cond[BQ_BIT]       = i_buffer_quarter_flag;
    // idle replaces bit 10 of the operation view
    op_cond                 = i_op_cond;
    op_cond[IDLE_BIT]       = i_idle;
  end

  // summaries from current events and enables every cycle
  assign msum_sum  = |(st_ff.msum_ev & st_ff.msum_en);
  assign minst_sum = |(st_ff.minst_ev & st_ff.minst_en);
  assign meas_sum  = |(st_ff.meas_ev & st_ff.meas_en);
  assign cmd       = i_cmd_valid;
  assign talk      = is_cmd(cmd, i_cmd_op, CMD_TALK);

  // strobes of the command taken this cycle
  assign rd_ev_msum  = is_cmd(cmd, i_cmd_op, CMD_RD_EV_MSUM);
  assign rd_ev_minst = is_cmd(cmd, i_cmd_op, CMD_RD_EV_MINST);
  assign rd_ev_meas  = is_cmd(cmd, i_cmd_op, CMD_RD_EV_MEAS);
  assign clr_status  = is_cmd(cmd, i_cmd_op, CMD_CLS);
  assign clr_errors  = is_cmd(cmd, i_cmd_op, CMD_ERR_CLR);
  assign wr_en_msum  = is_cmd(cmd, i_cmd_op, CMD_WR_EN_MSUM);
  assign wr_en_minst = is_cmd(cmd, i_cmd_op, CMD_WR_EN_MINST);
  assign wr_en_meas  = is_cmd(cmd, i_cmd_op, CMD_WR_EN_MEAS);
  assign wr_sre      = is_cmd(cmd, i_cmd_op, CMD_WR_SRE);
  assign rd_err      = is_cmd(cmd, i_cmd_op, CMD_RD_ERR);
  assign poll        = is_cmd(cmd, i_cmd_op, CMD_SPOLL);

  // error queue holds nothing
  assign eq_empty    = (st_ff.eq_cnt == '0);

  // status byte summary bits and master summary
  always_comb begin
    stb               = '0;
    stb[STB_MEAS_BIT] = meas_sum;
    stb[STB_EAV_BIT]  = !eq_empty;
    stb[STB_MAV_BIT]  = mav;
    mss               = |(stb & st_ff.sre & STB_SUM_MASK);
  end

  // output queue buffer; drained only by a talk command
  stream_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (OUT_DEPTH)
  ) u_outq (
    .i_sys_clk   (i_sys_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (i_resp_valid),
    .i_in_data   (i_resp_data),
    .o_in_ready  (o_resp_ready),
    .o_out_valid (mav),
    .o_out_data  (outq_data),
    .i_out_ready (talk)
  );

  // next free error slot as it stands after this cycle's pop or clear
  assign eq_wr = (clr_status || clr_errors) ? '0 : st_ff.eq_rd + st_ff.eq_cnt[EW-1:0];

  // event latching, command decode, queues and service request
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.rsp_valid   = 1'b0;
    nxt_st.msum_cond_d = msum_cond;
    nxt_st.mss_d       = mss;
    // read-clears and clear-status first, so new events win below
    if (rd_ev_msum) begin
      nxt_st.msum_ev = '0;
    end
    if (rd_ev_minst) begin
      nxt_st.minst_ev = '0;
    end
    if (rd_ev_meas) begin
      nxt_st.meas_ev = '0;
    end
    if (clr_status) begin
      nxt_st.msum_ev  = '0;
      nxt_st.minst_ev = '0;
      nxt_st.meas_ev  = '0;
    end
    if (clr_status || clr_errors) begin
      nxt_st.eq_cnt = '0;
      nxt_st.eq_rd  = '0;
    end
    // latch rising conditions; a new condition edge wins over any clear
    nxt_st.msum_ev = nxt_st.msum_ev
                   | (msum_cond & ~st_ff.msum_cond_d & MSUM_USED);
    // lower summaries feed upward, except in a clear-status cycle; a read-clear does not block them
    if (msum_sum && !clr_status) begin
      nxt_st.minst_ev[LOWER_SUM_BIT] = 1'b1;
    end
    if (minst_sum && !clr_status) begin
      nxt_st.meas_ev[INST_SUM_BIT] = 1'b1;
    end
    // enable writes
    if (wr_en_msum) begin
      nxt_st.msum_en = i_cmd_data & MSUM_USED;
    end
    if (wr_en_minst) begin
      nxt_st.minst_en = i_cmd_data;
    end
    if (wr_en_meas) begin
      nxt_st.meas_en = i_cmd_data;
    end
    if (wr_sre) begin
      nxt_st.sre = i_cmd_data[7:0] & STB_SUM_MASK;
    end
    // error read pops the head; empty queue answers no error
    if (rd_err && !eq_empty) begin
      nxt_st.eq_rd  = st_ff.eq_rd + 1'b1;
      nxt_st.eq_cnt = nxt_st.eq_cnt - 1'b1;
    end
    // error push behind the pop; the last free slot takes the overflow code
    if (i_err_valid && (nxt_st.eq_cnt != (EW + 1)'(ERR_DEPTH))) begin
      if (nxt_st.eq_cnt == (EW + 1)'(ERR_DEPTH - 1)) begin
        nxt_st.eq_mem[eq_wr] = ERR_OVERFLOW;
      end else begin
        nxt_st.eq_mem[eq_wr] = i_err_code;
      end
      nxt_st.eq_cnt = nxt_st.eq_cnt + 1'b1;
    end
    // request service on a rising master summary; a poll clears it
    if (poll) begin
      nxt_st.rqs = 1'b0;
    end
    // a new rise in the same cycle as a poll wins
    if (mss && !st_ff.mss_d) begin
      nxt_st.rqs = 1'b1;
    end
    // answer to reads
    if (cmd) begin
      nxt_st.rsp_valid = 1'b1;
      unique case (i_cmd_op)
        // live conditions
        CMD_RD_COND_MEAS: nxt_st.rsp_data = msum_cond;
        CMD_RD_COND_OP:   nxt_st.rsp_data = op_cond;
        CMD_RD_COND_QUES: nxt_st.rsp_data = i_ques_cond;
        // latched events and enables
        CMD_RD_EV_MSUM:   nxt_st.rsp_data = st_ff.msum_ev;
        CMD_RD_EV_MINST:  nxt_st.rsp_data = st_ff.minst_ev;
        CMD_RD_EV_MEAS:   nxt_st.rsp_data = st_ff.meas_ev;
        CMD_RD_EN_MSUM:   nxt_st.rsp_data = st_ff.msum_en;
        CMD_RD_EN_MINST:  nxt_st.rsp_data = st_ff.minst_en;
        CMD_RD_EN_MEAS:   nxt_st.rsp_data = st_ff.meas_en;
        CMD_RD_SRE:       nxt_st.rsp_data = {8'h00, st_ff.sre};
        // status byte, error queue and output queue
        CMD_RD_STB:       nxt_st.rsp_data = stb_word(stb, mss);
        CMD_SPOLL:        nxt_st.rsp_data = stb_word(stb, st_ff.rqs);
        CMD_RD_ERR: begin
          nxt_st.rsp_data = eq_empty ? ERR_NONE
                          : st_ff.eq_mem[st_ff.eq_rd];
        end
        CMD_TALK:         nxt_st.rsp_data = mav ? outq_data : RESET_WORD;
        default: begin
          nxt_st.rsp_valid = 1'b0;
        end
      endcase
    end
  end

  // outputs leave straight from the state register
  assign o_rsp_valid = st_ff.rsp_valid;
  assign o_rsp_data  = st_ff.rsp_data;
  assign o_srq       = st_ff.rqs;

  // state register; error queue empty from power-up
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ---- test/status_props.sv ----
// checker: command answers, live condition views and poll answer
// assumes binding onto the status block top, ports named as there
`timescale 1ns/100ps
module status_props
  import status_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_arst_n,
  input wire logic        i_reading_overflow_flag,
  input wire logic        i_reading_available_flag,
  input wire logic        i_buffer_half_flag,
  input wire logic        i_buffer_full_flag,
  input wire logic        i_buffer_three_quarter_flag,
  input wire logic        i_buffer_quarter_flag,
  input wire logic        i_idle,
  input wire logic [15:0] i_ques_cond,
  input wire logic        i_cmd_valid,
  input wire cmd_t        i_cmd_op,
  input wire logic        o_rsp_valid,
  input wire logic [15:0] o_rsp_data,
  input wire logic        o_srq,
  input wire logic        o_resp_ready
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  logic        rd;
  logic [15:0] cond;
  // read commands are all but the writes and the two clears
  assign rd = i_cmd_valid && !(i_cmd_op inside {CMD_WR_EN_MSUM, CMD_WR_EN_MINST,
              CMD_WR_EN_MEAS, CMD_WR_SRE, CMD_CLS, CMD_ERR_CLR});
  assign cond = {5'h00, i_buffer_quarter_flag, i_buffer_three_quarter_flag,
                 i_buffer_full_flag, i_buffer_half_flag, i_reading_available_flag,
                 5'h00, i_reading_overflow_flag};
  a_read_answer:
    assert property (rd |=> o_rsp_valid) else $error("read got no answer");
  a_write_silent:
    assert property (i_cmd_valid && !rd |=> !o_rsp_valid) else $error("write answered");
  a_answer_cause:
    assert property (o_rsp_valid |-> $past(rd)) else $error("answer without read");
  a_data_stands:
    assert property (!o_rsp_valid |-> $stable(o_rsp_data)) else $error("answer data moved");
  a_meas_cond_live:
    assert property (i_cmd_valid && i_cmd_op == CMD_RD_COND_MEAS |=> o_rsp_data == $past(cond))
      else $error("measurement condition wrong");
  a_idle_cond:
    assert property (i_cmd_valid && i_cmd_op == CMD_RD_COND_OP |=>
      o_rsp_data[IDLE_BIT] == $past(i_idle)) else $error("idle bit wrong");
  a_ques_cond:
    assert property (i_cmd_valid && i_cmd_op == CMD_RD_COND_QUES |=>
      o_rsp_data == $past(i_ques_cond)) else $error("questionable condition wrong");
  a_poll_rqs:
    assert property (i_cmd_valid && i_cmd_op == CMD_SPOLL |=>
      o_rsp_data[STB_RQS_BIT] == $past(o_srq)) else $error("poll bit 6 wrong");
  a_ready_after_reset:
    assert property ($rose(i_arst_n) |-> o_resp_ready) else $error("queue not ready");
endmodule

// ---- test/host_model.sv ----
// host controller model: sends one command and takes its answer
// assumes a read is answered exactly one cycle after it is taken
`timescale 1ns/100ps
module host_model
  import status_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rsp_valid,
  input  wire logic [15:0] i_rsp_data,
  output logic             o_cmd_valid,
  output cmd_t             o_cmd_op,
  output logic [15:0]      o_cmd_data
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_op    = CMD_RD_STB;
    o_cmd_data  = 16'h0000;
  end
  // query is sent first, its data is read back after the taking edge
  task automatic xfer(input cmd_t op, input logic [15:0] d, output logic [15:0] r);
    @(posedge i_sys_clk);
    #1;
    o_cmd_valid = 1'b1;
    o_cmd_op    = op;
    o_cmd_data  = d;
    @(posedge i_sys_clk);
    #1;
    o_cmd_valid = 1'b0;
    o_cmd_data  = ~d; // released data does not keep its value
    r = (i_rsp_valid === 1'b1) ? i_rsp_data : 16'hxxxx;
  endtask
endmodule

// ---- test/tb_instrument_status_reporting.sv ----
// testbench: conditions, event chain and service request, both queues
// assumes the host model drives the command port
`timescale 1ns/100ps
module tb_instrument_status_reporting
  import status_pkg::*;
;
  logic        i_sys_clk    = 1'b0;
  logic        i_arst_n     = 1'b0;
  logic [5:0]  fl           = 6'h00;
  logic        i_idle       = 1'b0;
  logic [15:0] i_op_cond    = 16'h0000;
  logic [15:0] i_ques_cond  = 16'h0000;
  logic        i_resp_valid = 1'b0;
  logic [15:0] i_resp_data  = 16'h0000;
  logic        i_err_valid  = 1'b0;
  logic [15:0] i_err_code   = 16'h0000;
  logic        i_cmd_valid, o_rsp_valid, o_srq, o_resp_ready;
  cmd_t        i_cmd_op;
  logic [15:0] i_cmd_data, o_rsp_data;
  int          fail_count   = 0;
  int          total_checks = 0;

  always #2 i_sys_clk = ~i_sys_clk;

  instrument_status_reporting DUT (.i_sys_clk, .i_arst_n, .i_reading_overflow_flag(fl[0]),
    .i_reading_available_flag(fl[1]), .i_buffer_half_flag(fl[2]), .i_buffer_full_flag(fl[3]),
    .i_buffer_three_quarter_flag(fl[4]), .i_buffer_quarter_flag(fl[5]), .i_idle, .i_op_cond,
    .i_ques_cond, .i_cmd_valid, .i_cmd_op, .i_cmd_data, .o_rsp_valid, .o_rsp_data, .o_srq,
    .i_resp_valid, .i_resp_data, .o_resp_ready, .i_err_valid, .i_err_code);
  host_model host (.i_sys_clk, .i_rsp_valid(o_rsp_valid), .i_rsp_data(o_rsp_data),
    .o_cmd_valid(i_cmd_valid), .o_cmd_op(i_cmd_op), .o_cmd_data(i_cmd_data));

  // shared helpers: compare, wait, command with and without answer
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic q(input cmd_t op, input logic [15:0] exp);
    logic [15:0] r;
    host.xfer(op, 16'h0000, r);
    check(r, exp);
  endtask
  task automatic w(input cmd_t op, input logic [15:0] d);
    logic [15:0] r;
    host.xfer(op, d, r);
  endtask
  task automatic err(input logic [15:0] c);
    tick(1);
    i_err_valid = 1'b1;
    i_err_code  = c;
    tick(1);
    i_err_valid = 1'b0;
  endtask

  // each flag alone, then the latched events read and cleared
  task automatic t_cond;
    for (int b = 0; b < 6; b++) begin
      tick(1);
      fl = 6'h01 << b;
      q(CMD_RD_COND_MEAS, {5'h00, fl[5:1], 5'h00, fl[0]});
    end
    fl          = 6'h00;
    i_op_cond   = 16'hffff;
    i_ques_cond = 16'ha5c3;
    q(CMD_RD_COND_OP, {5'h1f, i_idle, 10'h3ff});
    i_idle = 1'b1;
    q(CMD_RD_COND_OP, {5'h1f, i_idle, 10'h3ff});
    q(CMD_RD_COND_QUES, 16'ha5c3);
    q(CMD_RD_EV_MSUM, 16'h07c1);
    q(CMD_RD_EV_MSUM, 16'h0000);
    $display("t_cond done");
  endtask

  // buffer full through the enabled chain to a service request
  task automatic t_srq;
    w(CMD_WR_EN_MSUM, 16'h0100);
    w(CMD_WR_EN_MINST, 16'h0002);
    w(CMD_WR_EN_MEAS, 16'h2000);
    w(CMD_WR_SRE, 16'h0001);
    q(CMD_RD_EN_MSUM, 16'h0100);
    q(CMD_RD_EN_MINST, 16'h0002);
    q(CMD_RD_EN_MEAS, 16'h2000);
    q(CMD_RD_SRE, 16'h0001);
    fl[3] = 1'b1;
    tick(8);
    check({15'h0000, o_srq}, 16'h0001);
    q(CMD_RD_EV_MINST, 16'h0002);
    q(CMD_RD_EV_MEAS, 16'h2000);
    q(CMD_RD_STB, 16'h0041);
    q(CMD_SPOLL, 16'h0041);
    check({15'h0000, o_srq}, 16'h0000);
    q(CMD_RD_STB, 16'h0041);
    w(CMD_CLS, 16'h0000);
    q(CMD_RD_STB, 16'h0000);
    q(CMD_RD_EV_MEAS, 16'h0000);
    fl[3] = 1'b0;
    $display("t_srq done");
  endtask

  // error order, overflow entry, empty answer and both clears
  task automatic t_err;
    err(16'hff9c);
    err(16'h0005);
    q(CMD_RD_STB, 16'h0004);
    q(CMD_RD_ERR, 16'hff9c);
    q(CMD_RD_ERR, 16'h0005);
    q(CMD_RD_ERR, 16'h0000);
    q(CMD_RD_STB, 16'h0000);
    for (int i = 0; i < 70; i++) err(16'(i + 1));
    for (int i = 0; i < 64; i++) q(CMD_RD_ERR, (i == 63) ? 16'hfea2 : 16'(i + 1));
    q(CMD_RD_ERR, 16'h0000);
    err(16'h0007);
    w(CMD_ERR_CLR, 16'h0000);
    q(CMD_RD_ERR, 16'h0000);
    err(16'h0007);
    w(CMD_CLS, 16'h0000);
    q(CMD_RD_ERR, 16'h0000);
    $display("t_err done");
  endtask

  // output queue filled until refused, then drained in order
  task automatic t_outq;
    i_resp_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      i_resp_data = 16'h0a00 + 16'(i);
      check({15'h0000, o_resp_ready}, 16'h0001);
      tick(1);
    end
    check({15'h0000, o_resp_ready}, 16'h0000);
    tick(2);
    i_resp_valid = 1'b0;
    q(CMD_RD_STB, 16'h0010);
    for (int i = 0; i < 8; i++) q(CMD_TALK, 16'h0a00 + 16'(i));
    q(CMD_RD_STB, 16'h0000);
    $display("t_outq done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // watchdog well past the few hundred cycles the tests need
  initial begin
    #100000;
    fail_count++;
    results();
  end

  initial begin
    repeat (20) @(posedge i_sys_clk);
    #1;
    i_arst_n = 1'b1;
    t_cond();
    t_srq();
    t_err();
    t_outq();
    results();
  end
endmodule

bind instrument_status_reporting status_props chk (.i_sys_clk, .i_arst_n,
  .i_reading_overflow_flag, .i_reading_available_flag, .i_buffer_half_flag,
  .i_buffer_full_flag, .i_buffer_three_quarter_flag, .i_buffer_quarter_flag, .i_idle,
  .i_ques_cond, .i_cmd_valid, .i_cmd_op, .o_rsp_valid, .o_rsp_data, .o_srq, .o_resp_ready);
